// ---- verilog/sync_ctrl_pkg.sv ----
package sync_ctrl_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int FP_BASE_PERIOD_NS = 125000;
    localparam int FP_BASE_CYC = FP_BASE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int REF_LOSS_NS = 1000000;
    localparam int REF_LOSS_CYC = REF_LOSS_NS / CLK_PERIOD_NS;
    localparam int RESET_MIN_NS = 300;
    localparam logic [15:0] REF_PERIOD_TOL = 16'h0004;
    localparam logic [4:0] LOCK_CYC = 5'h10;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    // Synchronised pin positions
    localparam int P_SCK = 0;
    localparam int P_SI = 1;
    localparam int P_CSN = 2;
    localparam int P_MOD = 3;
    localparam int P_DIFF = 4;
    localparam int P_REF = 5;
    localparam int P_SYNC = 8;
    localparam int NPIN = 11;
    // Pulled-up pins idle high
    localparam logic [10:0] PIN_RST = 11'h01c;

    // Register byte addresses
    localparam logic [6:0] A_STATUS = 7'h00;
    localparam logic [6:0] A_REF_CTRL = 7'h01;
    localparam logic [6:0] A_MODE_CTRL = 7'h02;
    localparam logic [6:0] A_DIFF_CTRL = 7'h03;
    localparam logic [6:0] A_BANDWIDTH = 7'h04;
    localparam logic [6:0] A_LINE_CLK = 7'h05;
    localparam logic [6:0] A_DIFF_CLK = 7'h06;
    localparam logic [6:0] A_PROG_HI = 7'h07;
    localparam logic [6:0] A_PROG_LO = 7'h08;
    localparam logic [6:0] A_FP_LINE = 7'h09;
    localparam logic [6:0] A_FP_PROG = 7'h0a;
    localparam logic [6:0] A_DLY_FIRST = 7'h40;
    localparam logic [6:0] A_DLY_SECOND = 7'h58;

    // Field positions
    localparam int F_REF_MANUAL = 0;
    localparam int F_REF_FORCE = 1;
    localparam int F_MODE_SRC = 0;
    localparam int F_MODE_NORMAL = 1;
    localparam int F_MODE_STRAP = 7;
    localparam int F_DIFF_OVR = 0;
    localparam int F_DIFF_EN = 1;
    localparam int F_FP_RATE = 0;
    localparam int F_FP_WIDTH = 2;
    localparam int F_FP_POL = 5;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BANDWIDTH_RST = 8'h00;
    localparam logic [7:0] LINE_CLK_RST = 8'h00;
    localparam logic [7:0] DIFF_CLK_RST = 8'h00;
    localparam logic [13:0] PROG_MULT_RST = 14'h0100;
    localparam logic [7:0] FP_CFG_RST = 8'h00;
    localparam logic [21:0] DLY_RST = 22'h000000;

    typedef enum logic [2:0] {
        ST_FREERUN = 3'b001,
        ST_LOCKED = 3'b010,
        ST_HOLDOVER = 3'b100
    } loop_mode_e;

    typedef struct packed {
        logic [7:0] line_clk_sel;
        logic [7:0] diff_clk_sel;
        logic [13:0] prog_mult;
        logic [7:0] bandwidth;
        logic [1:0] ref_sel;
        logic [1:0][21:0] fp_delay;
    } synth_cfg_s;
endpackage

// ---- verilog/line_card_sync_control.sv ----
`timescale 1ns/1ns
module line_card_sync_control
    import sync_ctrl_pkg::*;
#(
    parameter int FP_BASE_CYCLES = FP_BASE_CYC,
    parameter int REF_LOSS_CYCLES = REF_LOSS_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Serial register port
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic cs_n_in,
    output logic so_out,
    // Control pins
    input wire logic mode_sel_in,
    input wire logic diff_en_in,
    // References and frame syncs
    input wire logic reference_input_zero_in,
    input wire logic reference_input_one_in,
    input wire logic reference_input_two_in,
    input wire logic frame_sync_input_zero_in,
    input wire logic frame_sync_input_one_in,
    input wire logic frame_sync_input_two_in,
    // Status, interrupt and outputs
    output logic lock_out,
    output logic holdover_out,
    output logic int_n_out,
    output logic int_oe_out,
    output logic diff_drv_en_out,
    output logic line_frame_pulse_out,
    output logic programmable_frame_pulse_out,
    output synth_cfg_s cfg_out
);
    typedef struct packed {
        logic [NPIN-1:0] s1, s2, s3;
        logic [1:0] strap_wait;
        logic strap_done, mode_default, rw, so, lock_o, hold_o, diff_o, irq;
        logic [4:0] bcnt, lock_cnt;
        logic [6:0] wa;
        logic [7:0] sh_in, sh_out, ref_ctrl, mode_ctrl, diff_ctrl, stat_prev;
        logic [1:0][7:0] fp_cfg;
        logic [1:0][13:0] dly_stage;
        logic [1:0][21:0] dly_snap;
        synth_cfg_s cfg;
        logic [2:0][15:0] ref_tmr, ref_last;
        logic [2:0] disq;
        loop_mode_e st;
        logic [1:0][15:0] fp_cnt;
        logic [1:0] fp_o;
    } state_s;

    state_s r, n;
    logic [NPIN-1:0] pins;
    logic sck_rise, sck_fall, normal_req, sel_ok;
    logic [7:0] byte_in, rdata, status;
    logic [6:0] addr, base;
    logic [15:0] per, diff;
    logic [1:0] ref_idx;

    default clocking main_cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    assign pins = {frame_sync_input_two_in, frame_sync_input_one_in,
                   frame_sync_input_zero_in, reference_input_two_in,
                   reference_input_one_in, reference_input_zero_in,
                   diff_en_in, mode_sel_in, cs_n_in, si_in, sck_in};
    assign sck_rise = r.s2[P_SCK] & ~r.s3[P_SCK];
    assign sck_fall = ~r.s2[P_SCK] & r.s3[P_SCK];
    assign byte_in = {r.sh_in[6:0], r.s2[P_SI]};
    assign addr = byte_in[6:0];
    assign status = {r.cfg.ref_sel, r.disq, r.st == ST_FREERUN,
                     r.hold_o, r.lock_o};
    assign normal_req = r.mode_ctrl[F_MODE_SRC] ?
                        r.mode_ctrl[F_MODE_NORMAL] : r.s2[P_MOD];
    // A forced index of 3 names no reference and never qualifies
    assign sel_ok = r.cfg.ref_sel != 2'h3 && !r.disq[r.cfg.ref_sel];

    // Read mux; first delay byte is live, later bytes come from the snapshot
    always_comb begin
        rdata = 8'h00;
        case (addr)
            A_STATUS: rdata = status;
            A_REF_CTRL: rdata = r.ref_ctrl;
            A_MODE_CTRL: rdata = {r.mode_default, r.mode_ctrl[6:0]};
            A_DIFF_CTRL: rdata = r.diff_ctrl;
            A_BANDWIDTH: rdata = r.cfg.bandwidth;
            A_LINE_CLK: rdata = r.cfg.line_clk_sel;
            A_DIFF_CLK: rdata = r.cfg.diff_clk_sel;
            A_PROG_HI: rdata = {2'h0, r.cfg.prog_mult[13:8]};
            A_PROG_LO: rdata = r.cfg.prog_mult[7:0];
            A_FP_LINE: rdata = r.fp_cfg[0];
            A_FP_PROG: rdata = r.fp_cfg[1];
            A_DLY_FIRST: rdata = {2'h0, r.cfg.fp_delay[0][21:16]};
            A_DLY_FIRST + 7'h01: rdata = r.dly_snap[0][15:8];
            A_DLY_FIRST + 7'h02: rdata = r.dly_snap[0][7:0];
            A_DLY_SECOND: rdata = {2'h0, r.cfg.fp_delay[1][21:16]};
            A_DLY_SECOND + 7'h01: rdata = r.dly_snap[1][15:8];
            A_DLY_SECOND + 7'h02: rdata = r.dly_snap[1][7:0];
            default: rdata = 8'h00;
        endcase
    end

    always_comb begin
        n = r;
        per = 16'h0000;
        diff = 16'h0000;
        ref_idx = 2'h0;
        base = 7'h00;
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // Strap waits for the synchroniser to carry the real pin level
        if (!r.strap_done) begin
            if (r.strap_wait == STRAP_WAIT) begin
                n.strap_done = 1'b1;
                n.mode_default = r.s2[P_MOD];
            end else begin
                n.strap_wait = r.strap_wait + 2'h1;
            end
        end
        // Serial port: rw bit, 7 address bits, 8 data bits, MSB first
        if (r.s2[P_CSN]) begin
            n.bcnt = 5'h00;
        end else if (sck_rise && r.bcnt != 5'h10) begin
            n.sh_in = byte_in;
            n.bcnt = r.bcnt + 5'h01;
            if (r.bcnt == 5'h07) begin
                n.rw = byte_in[7];
                // Shifter loses the address while data bits arrive
                n.wa = addr;
                n.sh_out = rdata;
                if (byte_in[7]) begin
                    if (addr == A_DLY_FIRST) begin
                        n.dly_snap[0] = r.cfg.fp_delay[0];
                    end
                    if (addr == A_DLY_SECOND) begin
                        n.dly_snap[1] = r.cfg.fp_delay[1];
                    end
                    if (addr == A_STATUS) begin
                        n.irq = 1'b0;
                    end
                end
            end
            if (r.bcnt == 5'h0f && !r.rw) begin
                case (r.wa)
                    A_REF_CTRL: n.ref_ctrl = byte_in;
                    A_MODE_CTRL: n.mode_ctrl = byte_in;
                    A_DIFF_CTRL: n.diff_ctrl = byte_in;
                    A_BANDWIDTH: n.cfg.bandwidth = byte_in;
                    A_LINE_CLK: n.cfg.line_clk_sel = byte_in;
                    A_DIFF_CLK: n.cfg.diff_clk_sel = byte_in;
                    A_PROG_HI: n.cfg.prog_mult[13:8] = byte_in[5:0];
                    A_PROG_LO: n.cfg.prog_mult[7:0] = byte_in;
                    A_FP_LINE: n.fp_cfg[0] = byte_in;
                    A_FP_PROG: n.fp_cfg[1] = byte_in;
                    default: n.rw = r.rw;
                endcase
                for (int k = 0; k < 2; k++) begin
                    base = (k == 0) ? A_DLY_FIRST : A_DLY_SECOND;
                    if (r.wa == base) begin
                        n.dly_stage[k][13:8] = byte_in[5:0];
                    end
                    if (r.wa == base + 7'h01) begin
                        n.dly_stage[k][7:0] = byte_in;
                    end
                    if (r.wa == base + 7'h02) begin
                        n.cfg.fp_delay[k] = {r.dly_stage[k], byte_in};
                    end
                end
            end
        end else if (sck_fall && r.rw && r.bcnt >= 5'h08) begin
            n.so = r.sh_out[7];
            n.sh_out = {r.sh_out[6:0], 1'b0};
        end
        // Reference monitor: period jump or silence disqualifies
        for (int i = 0; i < 3; i++) begin
            if (r.s2[P_REF+i] && !r.s3[P_REF+i]) begin
                diff = (r.ref_tmr[i] > r.ref_last[i]) ?
                       r.ref_tmr[i] - r.ref_last[i] :
                       r.ref_last[i] - r.ref_tmr[i];
                n.disq[i] = diff > REF_PERIOD_TOL;
                n.ref_last[i] = r.ref_tmr[i];
                n.ref_tmr[i] = 16'h0000;
            end else if (r.ref_tmr[i] >= 16'(REF_LOSS_CYCLES)) begin
                n.disq[i] = 1'b1;
            end else begin
                n.ref_tmr[i] = r.ref_tmr[i] + 16'h0001;
            end
        end
        // Selection: lowest qualified index, or the forced one
        if (r.ref_ctrl[F_REF_MANUAL]) begin
            n.cfg.ref_sel = r.ref_ctrl[F_REF_FORCE +: 2];
        end else begin
            for (int i = 2; i >= 0; i--) begin
                if (!r.disq[i]) begin
                    n.cfg.ref_sel = 2'(i);
                end
            end
        end
        // Switching between qualified references keeps the lock count; a switch forced by loss goes through holdover
        case (r.st)
            ST_FREERUN: begin
                if (normal_req && sel_ok) begin
                    n.st = ST_LOCKED;
                    n.lock_cnt = 5'h00;
                end
            end
            ST_LOCKED: begin
                if (!normal_req) begin
                    n.st = ST_FREERUN;
                end else if (!sel_ok) begin
                    n.st = ST_HOLDOVER;
                end else if (r.lock_cnt != LOCK_CYC) begin
                    n.lock_cnt = r.lock_cnt + 5'h01;
                end
            end
            ST_HOLDOVER: begin
                if (!normal_req) begin
                    n.st = ST_FREERUN;
                end else if (sel_ok) begin
                    n.st = ST_LOCKED;
                    n.lock_cnt = 5'h00;
                end
            end
            default: n.st = ST_FREERUN;
        endcase
        n.lock_o = n.st == ST_LOCKED && n.lock_cnt == LOCK_CYC;
        n.hold_o = n.st == ST_HOLDOVER;
        // Frame pulses restart on the selected reference's sync edge
        ref_idx = r.cfg.ref_sel;
        for (int k = 0; k < 2; k++) begin
            per = 16'(FP_BASE_CYCLES) << r.fp_cfg[k][F_FP_RATE +: 2];
            if (r.s2[P_SYNC+ref_idx] && !r.s3[P_SYNC+ref_idx]) begin
                n.fp_cnt[k] = 16'h0000;
            end else if (r.fp_cnt[k] >= per - 16'h0001) begin
                n.fp_cnt[k] = 16'h0000;
            end else begin
                n.fp_cnt[k] = r.fp_cnt[k] + 16'h0001;
            end
            n.fp_o[k] = (n.fp_cnt[k] <=
                         16'(r.fp_cfg[k][F_FP_WIDTH +: 3])) ^
                        r.fp_cfg[k][F_FP_POL];
        end
        n.diff_o = r.diff_ctrl[F_DIFF_OVR] ?
                   r.diff_ctrl[F_DIFF_EN] : r.s2[P_DIFF];
        n.stat_prev = status;
        if (status != r.stat_prev) begin
            n.irq = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r <= '0;
            r.s1 <= PIN_RST;
            r.s2 <= PIN_RST;
            r.s3 <= PIN_RST;
            r.mode_default <= 1'b1;
            r.ref_ctrl <= CTRL_RST;
            r.mode_ctrl <= CTRL_RST;
            r.diff_ctrl <= CTRL_RST;
            r.fp_cfg <= {FP_CFG_RST, FP_CFG_RST};
            r.cfg.bandwidth <= BANDWIDTH_RST;
            r.cfg.line_clk_sel <= LINE_CLK_RST;
            r.cfg.diff_clk_sel <= DIFF_CLK_RST;
            r.cfg.prog_mult <= PROG_MULT_RST;
            r.cfg.fp_delay <= {DLY_RST, DLY_RST};
            r.disq <= 3'h7;
            r.st <= ST_FREERUN;
            r.diff_o <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign so_out = r.so;
    assign lock_out = r.lock_o;
    assign holdover_out = r.hold_o;
    assign int_n_out = 1'b0;
    assign int_oe_out = r.irq;
    assign diff_drv_en_out = r.diff_o;
    assign line_frame_pulse_out = r.fp_o[0];
    assign programmable_frame_pulse_out = r.fp_o[1];
    assign cfg_out = r.cfg;

    AST_DLY_ATOMIC: assert property (
        $changed(r.cfg.fp_delay[0]) |-> $past(r.bcnt) == 5'h0f
            && $past(r.wa) == A_DLY_FIRST + 7'h02)
        else $error("delay offset changed without last-byte write");
    AST_AUTO_SEL: assert property (
        (!r.ref_ctrl[F_REF_MANUAL] && !r.disq[0]) |=> r.cfg.ref_sel == 2'h0)
        else $error("auto selection skipped qualified reference 0");
    AST_REF_LOSS: assert property (
        (r.ref_tmr[1] >= 16'(REF_LOSS_CYCLES)) |=> r.disq[1])
        else $error("silent reference not disqualified");
    AST_LOCK_STATE: assert property (
        lock_out |-> r.st == ST_LOCKED && r.lock_cnt == LOCK_CYC)
        else $error("lock shown outside settled locked state");
    AST_HOLDOVER: assert property (
        (r.st == ST_LOCKED && normal_req && !sel_ok) |=> holdover_out ##1 1'b1)
        else $error("loss of reference did not enter holdover");
    AST_STRAP: assert property (
        $rose(r.strap_done) |-> r.mode_default == $past(r.s2[P_MOD]))
        else $error("strap latched wrong level");
    AST_MODE_PIN: assert property (
        (!r.mode_ctrl[F_MODE_SRC] && !r.s2[P_MOD]) |=> r.st == ST_FREERUN)
        else $error("low mode pin did not force freerun");
    AST_DIFF_EN: assert property (
        !r.diff_ctrl[F_DIFF_OVR] |=> diff_drv_en_out == $past(r.s2[P_DIFF]))
        else $error("differential enable does not follow pin");
    AST_FP_START: assert property (
        (n.fp_cnt[0] == 16'h0000) |=> line_frame_pulse_out
            != $past(r.fp_cfg[0][F_FP_POL]))
        else $error("frame pulse not active at period start");
    AST_INT_SET: assert property (
        (status != r.stat_prev) |=> int_oe_out)
        else $error("status change did not raise interrupt");
endmodule

// ---- tb/ref_source.sv ----
`timescale 1ns/1ns
module ref_source (
    // Run enable per reference
    input wire logic [2:0] run_in,
    // Frame sync level per reference
    input wire logic [2:0] pulse_in,
    // Reference and frame sync pins
    output logic [2:0] ref_out,
    output logic [2:0] sync_out
);
    logic osc0, osc1, osc2;

    // 1 MHz, 800 kHz and 2 MHz, unrelated phases
    initial begin
        osc0 = 1'b0;
        #7 forever #500 osc0 = ~osc0;
    end
    initial begin
        osc1 = 1'b0;
        #13 forever #625 osc1 = ~osc1;
    end
    initial begin
        osc2 = 1'b0;
        #3 forever #250 osc2 = ~osc2;
    end

    // Stopped pins fall to their pull-down
    assign ref_out = {osc2, osc1, osc0} & run_in;
    // Plain pulse style; only the rising edge realigns
    assign sync_out = pulse_in;
endmodule

// ---- tb/line_card_sync_control_test.sv ----
`timescale 1ns/1ns
module line_card_sync_control_test;
    import sync_ctrl_pkg::*;
    localparam int FPB = 20;
    logic mclk_in, reset_n_in, sck_in, si_in, cs_n_in, so_out;
    logic mode_sel_in, diff_en_in, lock_out, holdover_out;
    logic int_n_out, int_oe_out, diff_drv_en_out, lfp, pfp;
    logic [2:0] run, refs, syncs, fs;
    synth_cfg_s cfg_out;
    int n_errors, checked, w, p;
    logic [7:0] rd, v8, got;
    logic [13:0] v14;
    logic [21:0] dv, old;
    logic [6:0] base;
    logic [1:0] dreg [4] = '{2'b00, 2'b00, 2'b11, 2'b01};
    logic de;

    line_card_sync_control #(
        .FP_BASE_CYCLES(FPB),
        .REF_LOSS_CYCLES(50)
    ) i_dut (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .sck_in(sck_in), .si_in(si_in), .cs_n_in(cs_n_in),
        .so_out(so_out), .mode_sel_in(mode_sel_in),
        .diff_en_in(diff_en_in),
        .reference_input_zero_in(refs[0]),
        .reference_input_one_in(refs[1]),
        .reference_input_two_in(refs[2]),
        .frame_sync_input_zero_in(syncs[0]),
        .frame_sync_input_one_in(syncs[1]),
        .frame_sync_input_two_in(syncs[2]),
        .lock_out(lock_out), .holdover_out(holdover_out),
        .int_n_out(int_n_out), .int_oe_out(int_oe_out),
        .diff_drv_en_out(diff_drv_en_out),
        .line_frame_pulse_out(lfp),
        .programmable_frame_pulse_out(pfp),
        .cfg_out(cfg_out)
    );
    ref_source i_src (.run_in(run), .pulse_in(fs), .ref_out(refs),
                      .sync_out(syncs));

    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end

    task automatic report_and_stop();
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t reg got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_pin(input logic [21:0] g, input logic [21:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t pin got %h exp %h", $time, g, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // Slow serial clock: five system cycles per half period
    task automatic xfer(input logic rw, input logic [6:0] a,
                        input logic [7:0] wd, output logic [7:0] r);
        logic [15:0] f;
        f = {rw, a, wd};
        r = 8'h00;
        cs_n_in = 1'b0;
        tick(5);
        for (int i = 15; i >= 0; i--) begin
            si_in = f[i];
            tick(5);
            if (i < 8) r[i] = so_out;
            sck_in = 1'b1;
            tick(5);
            sck_in = 1'b0;
        end
        tick(5);
        cs_n_in = 1'b1;
        si_in = ~si_in;
        tick(6);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        xfer(1'b0, a, d, x);
    endtask

    function automatic logic cond(input int k, input logic [1:0] v);
        case (k)
            0: return lock_out === v[0];
            1: return holdover_out === v[0];
            2: return diff_drv_en_out === v[0];
            3: return int_oe_out === v[0];
            default: return cfg_out.ref_sel === v;
        endcase
    endfunction

    task automatic wait_until(input int k, input logic [1:0] v,
                              input int lim);
        int c;
        c = 0;
        while (!cond(k, v) && c < lim) begin
            tick(1);
            c++;
        end
        checked++;
        if (!cond(k, v)) begin
            n_errors++;
            $display("[ERR] %0t wait %0d timed out", $time, k);
            report_and_stop();
        end
    endtask

    task automatic run_len(input logic pr, input logic lv, output int n);
        n = 0;
        while ((pr ? pfp : lfp) === lv) begin
            tick(1);
            n++;
            if (n > 400) begin
                n_errors++;
                $display("[ERR] %0t pulse stuck", $time);
                report_and_stop();
            end
        end
    endtask

    // Skips the partial pulse so a config change mid-count is harmless
    task automatic fp_meas(input logic pr, input logic act,
                           output int wd, output int per);
        int x;
        run_len(pr, act, x);
        run_len(pr, ~act, x);
        run_len(pr, act, wd);
        run_len(pr, ~act, x);
        per = wd + x;
    endtask

    task automatic do_reset(input logic strap);
        reset_n_in = 1'b0;
        mode_sel_in = strap;
        tick(6);
        dv = 22'({cfg_out.line_clk_sel, cfg_out.diff_clk_sel});
        chk_pin(dv, 22'h0);
        chk_pin(22'({int_n_out, int_oe_out}), 22'h0);
        chk_pin(22'(cfg_out.prog_mult), 22'(2048 / 8));
        chk_pin(22'({lock_out, holdover_out, lfp, pfp}), 22'h0);
        tick(6);
        reset_n_in = 1'b1;
        tick(4);
    endtask

    initial begin
        w = $urandom(32'hab773506);
        n_errors = 0;
        checked = 0;
        {reset_n_in, sck_in, si_in} = 3'b000;
        {cs_n_in, mode_sel_in, diff_en_in} = 3'b111;
        run = 3'h7;
        fs = 3'h0;
        do_reset(1'b1);
        xfer(1'b1, A_MODE_CTRL, 8'h00, rd);
        chk_reg(rd, 8'h80);
        for (int i = 0; i < 2; i++) begin
            fp_meas(i[0], 1'b1, w, p);
            chk_pin(22'(w * 1000 + p), 22'(1000 + FPB));
        end
        wait_until(0, 2'd1, 2000);
        wait_until(3, 2'd1, 10);
        xfer(1'b1, A_STATUS, 8'h00, rd);
        chk_reg(rd, 8'h01);
        wait_until(3, 2'd0, 50);
        for (int i = 0; i < 3; i++) begin
            v8 = 8'($urandom);
            wr(A_BANDWIDTH + 7'(i), v8);
            xfer(1'b1, A_BANDWIDTH + 7'(i), 8'h00, rd);
            got = (i == 0) ? cfg_out.bandwidth : (i == 1) ?
                cfg_out.line_clk_sel : cfg_out.diff_clk_sel;
            chk_reg(rd, v8);
            chk_reg(got, v8);
        end
        v14 = 14'($urandom);
        wr(A_PROG_HI, {2'b00, v14[13:8]});
        wr(A_PROG_LO, v14[7:0]);
        chk_pin(22'(cfg_out.prog_mult), 22'(v14));
        for (int k = 0; k < 2; k++) begin
            base = k[0] ? A_DLY_SECOND : A_DLY_FIRST;
            dv = k[0] ? 22'($urandom) : 22'h3fffff;
            old = cfg_out.fp_delay[k];
            wr(base, {2'b00, dv[21:16]});
            wr(base + 7'h1, dv[15:8]);
            chk_pin(cfg_out.fp_delay[k], old);
            wr(base + 7'h2, dv[7:0]);
            chk_pin(cfg_out.fp_delay[k], dv);
            for (int b = 0; b < 3; b++) begin
                xfer(1'b1, base + 7'(b), 8'h00, rd);
                v8 = 8'(dv >> (16 - 8 * b));
                chk_reg(rd, b == 0 ? v8 & 8'h3f : v8);
            end
        end
        wr(7'h7e, 8'hff);
        xfer(1'b1, 7'h7e, 8'h00, rd);
        chk_reg(rd, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v8 = (i == 0) ? 8'h2d : {2'b00, 6'($urandom)};
            wr(i == 0 ? A_FP_LINE : A_FP_PROG, v8);
            fp_meas(i != 0, ~v8[5], w, p);
            chk_pin(22'(w), 22'(v8[4:2]) + 22'd1);
            chk_pin(22'(p), 22'(FPB << v8[1:0]));
        end
        // Sync edge of the selected reference restarts the line pulse
        fs = 3'b001;
        tick(3);
        chk_pin(22'(lfp), 22'h0);
        tick(39);
        chk_pin(22'(lfp), 22'h1);
        tick(1);
        chk_pin(22'(lfp), 22'h0);
        fs = 3'b000;
        for (int i = 0; i < 4; i++) begin
            diff_en_in = i[0];
            wr(A_DIFF_CTRL, {6'h00, dreg[i]});
            de = dreg[i][0] ? dreg[i][1] : i[0];
            wait_until(2, {1'b0, de}, 20);
        end
        run = 3'b110;
        wait_until(4, 2'd1, 500);
        xfer(1'b1, A_STATUS, 8'h00, rd);
        chk_reg(rd & 8'hfe, 8'h48);
        wr(A_REF_CTRL, 8'h05);
        wait_until(4, 2'd2, 50);
        run = 3'b010;
        wait_until(1, 2'd1, 500);
        chk_pin(22'(lock_out), 22'h0);
        run = 3'h7;
        wr(A_REF_CTRL, 8'h00);
        wait_until(4, 2'd0, 500);
        wait_until(0, 2'd1, 2000);
        wr(A_MODE_CTRL, 8'h01);
        wait_until(0, 2'd0, 100);
        xfer(1'b1, A_STATUS, 8'h00, rd);
        chk_reg(rd & 8'h07, 8'h04);
        wr(A_MODE_CTRL, 8'h00);
        wait_until(0, 2'd1, 2000);
        mode_sel_in = 1'b0;
        wait_until(0, 2'd0, 100);
        do_reset(1'b0);
        mode_sel_in = 1'b1;
        xfer(1'b1, A_MODE_CTRL, 8'h00, rd);
        chk_reg(rd, 8'h00);
        report_and_stop();
    end
endmodule
